/* common/adcpc_pkg.sv */
// Package with register map, field layouts and timing constants.
package adcpc_pkg;

  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned TB_HZ    = 10_000_000;
  localparam int unsigned REF0_HZ  = 5_000_000;
  localparam int unsigned REF1_HZ  = 1_000_000;
  localparam int unsigned REF2_HZ  = 100_000;
  localparam int unsigned TB_DIV   = CLK_HZ / TB_HZ;
  localparam int unsigned REF0_DIV = TB_HZ / REF0_HZ;
  localparam int unsigned REF1_DIV = TB_HZ / REF1_HZ;
  localparam int unsigned REF2_DIV = TB_HZ / REF2_HZ;

  localparam int unsigned QDEPTH   = 256;
  localparam int unsigned QAW      = 8;
  localparam int unsigned DW       = 16;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_PACER = 8'h08;
  localparam logic [7:0] A_BURST = 8'h0C;
  localparam logic [7:0] A_QLEN  = 8'h10;
  localparam logic [7:0] A_QWR   = 8'h14;
  localparam logic [7:0] A_POST  = 8'h18;
  localparam logic [7:0] A_LEVEL = 8'h1C;
  localparam logic [7:0] A_STAT  = 8'h20;
  localparam logic [7:0] A_DATA  = 8'h24;

  // Command register bits, write-one pulses.
  localparam int unsigned CMD_CONV  = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_STOP  = 2;

  // Pacer source codes.
  localparam logic [1:0] SRC_SW  = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // Queue write word: address in [23:16], entry in [11:0].
  localparam int unsigned QWR_ADDR_LSB = 16;

  typedef struct packed {
    logic       atrig_en;    // [7] analog trigger armed in about-trigger
    logic       trig_neg;    // [6] falling edge on trigger input
    logic       mfi1_trig;   // [5] input one acts as trigger input
    logic       ext_neg;     // [4] falling edge on external pacer
    logic       mfi0_pacer;  // [3] input zero acts as external pacer
    logic [1:0] src;         // [2:1] pacer source
    logic       burst;       // [0] burst mode
  } adcpc_ctrl_t;

  localparam adcpc_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic [5:0] chan;
    logic [3:0] gain;
    logic       bipolar;
    logic       diff;
  } adcpc_entry_t;

  localparam int unsigned EW = $bits(adcpc_entry_t);

  typedef struct packed {
    logic [1:0]  ref_sel;    // [17:16] 5 MHz, 1 MHz, 100 kHz, 10 MHz
    logic [15:0] div;        // [15:0] reference ticks per pacer pulse
  } adcpc_pacer_t;

  typedef struct packed {
    logic [DW-1:0] thresh;   // [31:16]
    logic [DW-1:0] level;    // [15:0]
  } adcpc_level_t;

endpackage

/* core/adcpc_qram.sv */
// Channel-gain queue memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module adcpc_qram
  import adcpc_pkg::*;
#(
  parameter int unsigned AW = QAW,
  parameter int unsigned W  = EW
) (
  input  wire logic          i_core_clk, // Clock.
  input  wire logic          i_we,       // Write strobe.
  input  wire logic [AW-1:0] i_waddr,    // Write address.
  input  wire logic [W-1:0]  i_wdata,    // Write data.
  input  wire logic [AW-1:0] i_raddr,    // Read address.
  output logic      [W-1:0]  o_rdata     // Registered read data.
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem[i_raddr];
  end

endmodule
`default_nettype wire

/* core/adcpc_ctrl.sv */
// Converter pacing, burst sequencing and trigger control with APB slave.
// What this block does
// - Paced and burst modes with own clocks; paced mode after reset.
// - Paced mode converts one queue entry per pacer pulse.
// - In burst mode a pacer pulse after the start cycle starts a burst clock train unless one is already running.
// - Each burst pulse converts one entry; train stops after last entry.
// - Software conversion command; completion flag polled, then data read.
// - Internal pacer from 10 MHz time base with 5, 1, 0.1 MHz taps.
// - One shared internal pacing rate for every user.
// - External pacer taken on input zero only when configured so.
// - External pacer edge, rising or falling, chosen by software.
// - Only one pacer source, internal or external, at a time.
// - Software command starts or stops acquisition.
// - External trigger taken on input one only when configured so.
// - Trigger on rising edge if positive, falling edge if negative.
// - Analog trigger slope set by threshold versus trigger level.
// - Analog trigger ends acquisition after programmed sample count.
// - External pacer times conversions in paced, bursts in burst mode.
// - Queue holds up to 256 entries of channel, gain, polarity, wiring.
// - With external pacer a trigger only arms; edges start conversions.
`timescale 1ns/1ps
`default_nettype none
module adcpc_ctrl
  import adcpc_pkg::*;
(
  input  wire logic          i_core_clk,                 // 50 MHz clock.
  input  wire logic          i_resetn,                   // Async reset.
  input  wire logic          psel,                       // APB select.
  input  wire logic          penable,                    // APB enable.
  input  wire logic          pwrite,                     // APB direction.
  input  wire logic [7:0]    paddr,                      // APB address.
  input  wire logic [31:0]   pwdata,                     // APB write data.
  output logic      [31:0]   prdata,                     // APB read data.
  output logic               pready,                     // APB ready.
  output logic               pslverr,                    // APB error.
  input  wire logic          i_multi_function_input_zero, // Pacer pin.
  input  wire logic          i_multi_function_input_one,  // Trigger pin.
  output logic               o_conv_start,               // Start pulse.
  output adcpc_entry_t       o_conv_entry,               // Entry to convert.
  input  wire logic          i_conv_done,                // Result pulse.
  input  wire logic [DW-1:0] i_conv_data,                // Result value.
  output logic               o_acquiring                 // Acquisition on.
);

  typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_POST} adcpc_acq_t;

  adcpc_ctrl_t   ctrl_r;
  adcpc_pacer_t  pacer_r;
  adcpc_level_t  level_r;
  adcpc_acq_t    acq_r;
  logic [15:0]   burst_div_r;
  logic [QAW-1:0] qlen_r;
  logic [QAW-1:0] qptr_r;
  logic [15:0]   post_r;
  logic [15:0]   post_cnt_r;
  logic [DW-1:0] data_r;
  logic [DW-1:0] prev_r;
  logic          prev_ok_r;
  logic          done_r;
  logic          busy_r;
  logic          ready_r;
  logic          mfi0_q_r;
  logic          mfi1_q_r;
  logic [2:0]    tb_cnt_r;
  logic [6:0]    ref_cnt_r [3];
  logic [2:0]    ref_tick;
  logic          tb_tick;
  logic [15:0]   pac_cnt_r;
  logic [15:0]   bur_cnt_r;
  logic          ref_sel_tick;
  logic          int_tick;
  logic          ext_edge;
  logic          ext_trig;
  logic          start_cmd;
  logic          stop_cmd;
  logic          sw_conv;
  logic          start_any;
  logic          pacer_pulse;
  logic          burst_tick;
  logic          conv_go;
  logic          last_entry;
  logic          atrig_fire;
  logic          wr_en;
  logic          rd_go;
  adcpc_entry_t  qram_rdata;

  function automatic logic div_hit(input logic [15:0] cnt,
                                   input logic [15:0] div);
    div_hit = (cnt + 16'h0001) >= ((div == 16'h0000) ? 16'h0001 : div);
  endfunction

  function automatic logic edge_of(input logic now, input logic was,
                                   input logic neg);
    edge_of = neg ? (was & ~now) : (~was & now);
  endfunction

  // APB: one wait state, so that read data comes from a register.
  assign rd_go   = psel & penable & ~ready_r;
  assign pready  = psel & penable & ready_r;
  assign wr_en   = pready & pwrite;
  assign pslverr = pready & !(paddr inside {A_CTRL, A_CMD, A_PACER,
                   A_BURST, A_QLEN, A_QWR, A_POST, A_LEVEL, A_STAT,
                   A_DATA});

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= rd_go;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_go && !pwrite) begin
      unique case (paddr)
        A_CTRL:  prdata <= {24'h00_0000, ctrl_r};
        A_PACER: prdata <= {14'h0000, pacer_r};
        A_BURST: prdata <= {16'h0000, burst_div_r};
        A_QLEN:  prdata <= {24'h00_0000, qlen_r};
        A_POST:  prdata <= {16'h0000, post_r};
        A_LEVEL: prdata <= level_r;
        A_STAT:  prdata <= {20'h0_0000, qptr_r, busy_r,
                            acq_r != ACQ_IDLE, acq_r == ACQ_POST, done_r};
        A_DATA:  prdata <= {16'h0000, data_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r      <= CTRL_RST;
      pacer_r     <= '0;
      burst_div_r <= 16'h0000;
      qlen_r      <= '0;
      post_r      <= 16'h0000;
      level_r     <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        A_CTRL:  ctrl_r      <= adcpc_ctrl_t'(pwdata[7:0]);
        A_PACER: pacer_r     <= adcpc_pacer_t'(pwdata[17:0]);
        A_BURST: burst_div_r <= pwdata[15:0];
        A_QLEN:  qlen_r      <= pwdata[QAW-1:0];
        A_POST:  post_r      <= pwdata[15:0];
        A_LEVEL: level_r     <= pwdata;
        default: ;
      endcase
    end
  end

  assign start_cmd = wr_en && paddr == A_CMD && pwdata[CMD_START];
  assign stop_cmd  = wr_en && paddr == A_CMD && pwdata[CMD_STOP];
  assign sw_conv   = wr_en && paddr == A_CMD && pwdata[CMD_CONV]
                     && ctrl_r.src == SRC_SW;

  adcpc_qram #(.AW(QAW), .W(EW)) u_qram (
    .i_core_clk (i_core_clk),
    .i_we       (wr_en && paddr == A_QWR),
    .i_waddr    (pwdata[QWR_ADDR_LSB +: QAW]),
    .i_wdata    (pwdata[EW-1:0]),
    .i_raddr    (qptr_r),
    .o_rdata    (qram_rdata)
  );

  // Time base: 10 MHz enable, then 5 MHz, 1 MHz and 100 kHz taps.
  assign tb_tick = tb_cnt_r == 3'(TB_DIV - 1);
  assign ref_tick[0] = tb_tick && ref_cnt_r[0] == 7'(REF0_DIV - 1);
  assign ref_tick[1] = tb_tick && ref_cnt_r[1] == 7'(REF1_DIV - 1);
  assign ref_tick[2] = tb_tick && ref_cnt_r[2] == 7'(REF2_DIV - 1);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tb_cnt_r <= 3'h0;
      for (int i = 0; i < 3; i++) ref_cnt_r[i] <= 7'h00;
    end else begin
      tb_cnt_r <= tb_tick ? 3'h0 : tb_cnt_r + 3'h1;
      for (int i = 0; i < 3; i++) begin
        if (ref_tick[i]) ref_cnt_r[i] <= 7'h00;
        else if (tb_tick) ref_cnt_r[i] <= ref_cnt_r[i] + 7'h01;
      end
    end
  end

  // One pacer counter serves every user of the internal rate.
  assign ref_sel_tick = (pacer_r.ref_sel == 2'h3) ? tb_tick
                        : ref_tick[pacer_r.ref_sel];
  assign int_tick = ref_sel_tick && div_hit(pac_cnt_r, pacer_r.div);
  assign start_any = (acq_r == ACQ_IDLE) && (start_cmd || ext_trig);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pac_cnt_r <= 16'h0000;
    end else if (acq_r == ACQ_IDLE || int_tick) begin
      pac_cnt_r <= 16'h0000; // Counter idles until triggered.
    end else if (ref_sel_tick) begin
      pac_cnt_r <= pac_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mfi0_q_r <= 1'b0;
      mfi1_q_r <= 1'b0;
    end else begin
      mfi0_q_r <= i_multi_function_input_zero;
      mfi1_q_r <= i_multi_function_input_one;
    end
  end

  assign ext_edge = ctrl_r.mfi0_pacer &&
                    edge_of(i_multi_function_input_zero, mfi0_q_r,
                            ctrl_r.ext_neg);
  assign ext_trig = ctrl_r.mfi1_trig &&
                    edge_of(i_multi_function_input_one, mfi1_q_r,
                            ctrl_r.trig_neg);

  // Internal pacer fires at once on the start; external only arms.
  always_comb begin
    pacer_pulse = 1'b0;
    unique case (ctrl_r.src)
      SRC_INT: pacer_pulse = start_any ||
                             (acq_r != ACQ_IDLE && int_tick);
      SRC_EXT: pacer_pulse = acq_r != ACQ_IDLE && ext_edge;
      default: pacer_pulse = 1'b0;
    endcase
  end

  assign burst_tick = busy_r && tb_tick && div_hit(bur_cnt_r, burst_div_r);
  assign last_entry = qptr_r == qlen_r;
  assign conv_go    = sw_conv || (ctrl_r.burst ? burst_tick
                                               : pacer_pulse);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_r    <= 1'b0;
      bur_cnt_r <= 16'h0000;
    end else if (!ctrl_r.burst || acq_r == ACQ_IDLE) begin
      busy_r    <= 1'b0;
      bur_cnt_r <= 16'h0000;
    end else if (!busy_r) begin
      busy_r    <= pacer_pulse;
      bur_cnt_r <= 16'h0000;
    end else begin
      if (burst_tick && last_entry) busy_r <= 1'b0;
      if (burst_tick) bur_cnt_r <= 16'h0000;
      else if (tb_tick) bur_cnt_r <= bur_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      qptr_r <= '0;
    end else if (wr_en && paddr == A_QLEN) begin
      qptr_r <= '0;
    end else if (start_any) begin
      // A paced-mode internal-pacer start converts entry zero at once, so step past it.
      qptr_r <= (conv_go && qlen_r != '0) ? QAW'(1) : '0;
    end else if (conv_go) begin
      qptr_r <= last_entry ? '0 : qptr_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv_start <= 1'b0;
      o_conv_entry <= '0;
    end else begin
      o_conv_start <= conv_go;
      if (conv_go) o_conv_entry <= qram_rdata;
    end
  end

  // Analog slope: threshold above level means falling crossing.
  assign atrig_fire = ctrl_r.atrig_en && acq_r == ACQ_RUN && i_conv_done
      && prev_ok_r && ((level_r.thresh > level_r.level)
      ? (prev_r >= level_r.level && i_conv_data < level_r.level)
      : (prev_r < level_r.level && i_conv_data >= level_r.level));

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acq_r      <= ACQ_IDLE;
      post_cnt_r <= 16'h0000;
    end else begin
      unique case (acq_r)
        ACQ_IDLE: if (start_any) acq_r <= ACQ_RUN;
        ACQ_RUN: begin
          post_cnt_r <= 16'h0000;
          if (stop_cmd) acq_r <= ACQ_IDLE;
          else if (atrig_fire) acq_r <= ACQ_POST;
        end
        ACQ_POST: begin
          if (i_conv_done) post_cnt_r <= post_cnt_r + 16'h0001;
          if (stop_cmd || (i_conv_done && post_cnt_r + 16'h0001 >= post_r))
            acq_r <= ACQ_IDLE;
        end
      endcase
    end
  end

  assign o_acquiring = acq_r != ACQ_IDLE;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_r    <= '0;
      prev_r    <= '0;
      prev_ok_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      if (i_conv_done) begin
        data_r    <= i_conv_data;
        prev_r    <= i_conv_data;
        prev_ok_r <= acq_r == ACQ_RUN;
      end else if (acq_r == ACQ_IDLE) begin
        prev_ok_r <= 1'b0;
      end
      if (i_conv_done) done_r <= 1'b1;
      else if (rd_go && !pwrite && paddr == A_DATA) done_r <= 1'b0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  AST_PACED_DEFAULT: assert property ($rose(i_resetn) |-> !ctrl_r.burst)
    else $error("burst mode active straight after reset");
  AST_ONE_PER_PULSE: assert property (!ctrl_r.burst && pacer_pulse
      |=> o_conv_start ##1 (!o_conv_start || $past(conv_go)))
    else $error("paced pulse did not give exactly one conversion");
  AST_QUEUE_WRAP: assert property (conv_go && last_entry && !start_any
      && !(wr_en && paddr == A_QLEN) |=> qptr_r == '0)
    else $error("queue pointer did not wrap after last entry");
  AST_BURST_END: assert property (burst_tick && last_entry
      |=> !busy_r ##1 !o_conv_start)
    else $error("burst continued past last queue entry");
  AST_BURST_IGNORE: assert property (busy_r && pacer_pulse
      && !burst_tick && !sw_conv |=> $stable(qptr_r))
    else $error("pacer pulse disturbed a running burst");
  AST_EXT_ROLE: assert property (ctrl_r.src == SRC_EXT
      && !ctrl_r.mfi0_pacer |-> !pacer_pulse)
    else $error("external pacer used without its input role");
  AST_TRIG_ROLE: assert property (!ctrl_r.mfi1_trig |-> !ext_trig)
    else $error("trigger taken without its input role");
  AST_TIMEBASE: assert property (tb_tick |=> !tb_tick [*4] ##1 tb_tick)
    else $error("time base not one tick per five clocks");
  AST_DONE_SET: assert property (i_conv_done |=> done_r)
    else $error("completion flag not set after conversion");
  AST_EXT_ARMS: assert property (ctrl_r.src == SRC_EXT && start_any
      && !ext_edge |=> !o_conv_start)
    else $error("external pacer conversion without a pacer edge");

  COV_PACED: cover property (!ctrl_r.burst && conv_go && last_entry);
  COV_BURST: cover property (burst_tick && last_entry);
  COV_ATRIG: cover property (atrig_fire);
  COV_SWCONV: cover property (sw_conv ##[1:20] i_conv_done);

endmodule
`default_nettype wire

/* tb/adcpc_conv_model.sv */
// Converter model: answers each start with a result after a fixed latency.
`timescale 1ns/1ps
`default_nettype none
module adcpc_conv_model
  import adcpc_pkg::*;
#(
  parameter int unsigned LAT = 10
) (
  input  wire logic          i_core_clk,   // Clock.
  input  wire logic          i_resetn,     // Async reset.
  input  wire logic          i_conv_start, // Start pulse.
  input  wire adcpc_entry_t  i_conv_entry, // Entry to convert.
  output logic               o_conv_done,  // Result pulse.
  output logic      [DW-1:0] o_conv_data   // Result value.
);
  int unsigned   cnt_r;
  logic [DW-1:0] res_r;

  // The result bus carries junk outside the done pulse.
  assign o_conv_data = o_conv_done ? res_r : ~res_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 0;
      res_r <= '0;
      o_conv_done <= 1'b0;
    end else begin
      o_conv_done <= (cnt_r == 1);
      if (i_conv_start) begin
        cnt_r <= LAT;
        res_r <= {4'h5, i_conv_entry};
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_adc_pacing_burst_trigger_ctrl.sv */
// Self-checking bench for the pacing, burst and trigger controller.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_pacing_burst_trigger_ctrl
  import adcpc_pkg::*;
;
  logic          clk, rstn, psel, penable, pwrite, pin0, pin1;
  logic          pready, pslverr, er, cst, cdone, acq, g;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [DW-1:0] cdata;
  logic [15:0]   seed;
  adcpc_entry_t  cent, ent;
  adcpc_entry_t  q [3];
  int            miscompares, n_tests, t0, t1, i, k;
  int            cyc = 0;

  adcpc_ctrl DUT (
    .i_core_clk(clk), .i_resetn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .i_multi_function_input_zero(pin0), .i_multi_function_input_one(pin1),
    .o_conv_start(cst), .o_conv_entry(cent), .i_conv_done(cdone),
    .i_conv_data(cdata), .o_acquiring(acq));

  adcpc_conv_model conv (
    .i_core_clk(clk), .i_resetn(rstn), .i_conv_start(cst),
    .i_conv_entry(cent), .o_conv_done(cdone), .o_conv_data(cdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] exp_data(input adcpc_entry_t e);
    return {4'h5, e};
  endfunction

  task stop_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 0, 1);
      stop_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Looks for one start pulse within lim cycles.
  task wstart(input int lim, output logic got);
    got = 1'b0;
    for (int n = 0; n < lim && !got; n++) begin
      @(negedge clk);
      if (cst === 1'b1) begin
        got = 1'b1;
        ent = cent;
        t1 = cyc;
      end
    end
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pin0 = 1'b0;
    pin1 = 1'b0;
    seed = 16'h000F;
    miscompares = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    apb(0, A_CTRL, '0);
    chk("ctrl reset", rd, 0);
    apb(0, A_STAT, '0);
    chk("stat reset", rd, 0);
    apb(0, 8'h3C, '0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      q[i] = seed[11:0];
      apb(1, A_QWR, (32'(i) << QWR_ADDR_LSB) | 32'(seed[11:0]));
    end
    apb(1, A_QLEN, 32'h2);
    apb(1, A_CMD, 32'h1);
    wstart(10, g);
    chk("sw start", g, 1);
    chk("sw entry", ent, q[0]);
    k = 0;
    do begin
      apb(0, A_STAT, '0);
      k++;
    end while (rd[0] !== 1'b1 && k < 20);
    chk("sw done", rd[0], 1);
    apb(0, A_DATA, '0);
    chk("sw data", rd[15:0], exp_data(q[0]));
    apb(0, A_STAT, '0);
    chk("done clear", rd[0], 0);
    apb(1, A_QLEN, 32'h2);
    apb(1, A_PACER, 32'h0003000A);
    apb(1, A_CTRL, 32'h2);
    apb(1, A_CMD, 32'h2);
    for (i = 0; i < 4; i++) begin
      wstart(80, g);
      chk("paced start", g, 1);
      chk("paced entry", ent, q[i % 3]);
      if (i > 1) chk("pacer period", t1 - t0, TB_DIV * 10);
      t0 = t1;
    end
    chk("acquiring", acq, 1);
    apb(1, A_CMD, 32'h4);
    @(negedge clk);
    chk("stopped", acq, 0);
    wstart(100, g);
    chk("idle pacer", g, 0);
    apb(1, A_QLEN, 32'h2);
    apb(1, A_PACER, 32'h00020002);
    apb(1, A_BURST, 32'h4);
    apb(1, A_CTRL, 32'h3);
    apb(1, A_CMD, 32'h2);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 3; i++) begin
        wstart(1100, g);
        chk("burst start", g, 1);
        chk("burst entry", ent, q[i]);
        if (i == 2) chk("burst period", t1 - t0, TB_DIV * 4);
        t0 = t1;
      end
      wstart(400, g);
      chk("burst end", g, 0);
    end
    apb(1, A_CMD, 32'h4);
    for (k = 0; k < 2; k++) begin
      pin0 <= k[0];
      apb(1, A_QLEN, 32'h2);
      apb(1, A_CTRL, 32'h0C | (k << 4));
      apb(1, A_CMD, 32'h2);
      wstart(30, g);
      chk("armed only", g, 0);
      @(posedge clk);
      pin0 <= ~k[0];
      wstart(5, g);
      chk("ext start", g, 1);
      chk("ext entry", ent, q[0]);
      repeat (500) @(posedge clk);
      pin0 <= k[0];
      wstart(30, g);
      chk("wrong edge", g, 0);
      repeat (500) @(posedge clk);
      pin0 <= ~k[0];
      wstart(5, g);
      chk("ext next", g, 1);
      chk("ext next entry", ent, q[1]);
      apb(1, A_CMD, 32'h4);
    end
    apb(1, A_CTRL, 32'h04);
    apb(1, A_CMD, 32'h2);
    pin0 <= 1'b1;
    wstart(30, g);
    @(posedge clk);
    pin0 <= 1'b0;
    wstart(30, g);
    chk("pin not routed", g, 0);
    apb(1, A_CMD, 32'h4);
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      pin1 <= ~k[0];
      apb(1, A_CTRL, 32'h20 | (k << 6));
      @(posedge clk);
      pin1 <= k[0];
      repeat (5) @(negedge clk);
      chk("wrong trig", acq, 0);
      @(posedge clk);
      pin1 <= ~k[0];
      repeat (5) @(negedge clk);
      chk("trig", acq, 1);
      apb(1, A_CMD, 32'h4);
      @(negedge clk);
      chk("trig stop", acq, 0);
    end
    stop_test;
  end
endmodule
`default_nettype wire
